// file: hw/pbm_defs.svh
// register map, field positions, reset values and counts of the page buffer manager
`ifndef PBM_DEFS_SVH
`define PBM_DEFS_SVH
// register indices as printed; byte address is four times the index
`define TXSEL_IDX 16'h7F52
`define CMD_IDX 16'h7F53
`define ARES_IDX 16'h7F54
`define PSEL_IDX 16'h7F55
`define FREE_IDX 16'h7F56
`define TXSEL_ADDR 32'h0001FD48
`define CMD_ADDR 32'h0001FD4C
`define ARES_ADDR 32'h0001FD50
`define PSEL_ADDR 32'h0001FD54
`define FREE_ADDR 32'h0001FD58
// fields
`define OP_HI 7
`define OP_LO 5
`define CNT_HI 3
`define CNT_LO 0
`define FAIL_BIT 7
`define NAK_BIT 7
`define CNT_MAX 4'h9
`define FREE_RST 6'h20
`define NUM_PAGES 32
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// file: hw/pbm_pkg.sv
// types shared by the page buffer manager
package pbm_pkg;
    typedef enum logic [2:0] {
        OP_NOP, OP_ALLOCATION_COMPLETE_INTERRUPT, OP_RESET, OP_POP, OP_POPREL, OP_REL, OP_ENQ, OP_TXRST
    } op_e;
    typedef enum {ST_IDLE, ST_ALLOCATION_COMPLETE_INTERRUPT} allocation_complete_interrupt_st_e;
    typedef struct packed {
        logic [2:0] op;
        logic rsv;
        logic [3:0] cnt;
    } cmd_s;
    typedef struct packed {
        logic enq;
        logic flush;
        logic [3:0] ep;
        logic [4:0] pkt;
    } tx_cmd_s;
endpackage

// file: hw/packet_buffer_mmu.sv
// command and status side of the paged packet buffer manager
//
// The AXI4-Lite register port is this design's own decision.
`include "pbm_defs.svh"

module packet_buffer_mmu
    import pbm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // receive dma engine
    input wire logic rx_dma_page_req,
    input wire logic [4:0] rx_dma_pkt,
    input wire logic rx_dma_release,
    input wire logic [4:0] rx_dma_rel_pkt,
    output logic rx_dma_grant,
    output logic [4:0] rx_dma_page,
    // receive packet-number queue and nak
    input wire logic [4:0] rx_queue_head,
    output logic rx_queue_pop,
    output logic receive_nak_control,
    // transmit queues, reset, completion
    output tx_cmd_s tx_cmd,
    output logic mmu_reset,
    output logic allocation_complete
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic aw_full_reg, w_full_reg, w_en_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [3:0] tx_queue_select_reg;
    logic [4:0] packet_select_reg, result_pkt_reg, pkt_reg;
    logic failed_reg, nak_reg, first_reg;
    logic [3:0] need_reg;
    logic [5:0] free_cnt_reg;
    logic [31:0] page_used_reg;
    logic [4:0] page_tag_reg [`NUM_PAGES];
    allocation_complete_interrupt_st_e st_reg;
    tx_cmd_s tx_reg;
    logic pop_reg, rst_pulse_reg, done_reg, grant_reg;
    logic [4:0] grant_page_reg;

    // ------------------------------------------------------------
    // write channel decode
    // ------------------------------------------------------------
    wire aw_hs = awvalid && awready_reg;
    wire w_hs = wvalid && wready_reg;
    wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    wire aw_full_next = aw_hs || (aw_full_reg && !wr_fire);
    wire w_full_next = w_hs || (w_full_reg && !wr_fire);
    wire wr_txsel = aw_addr_reg == `TXSEL_ADDR;
    wire wr_cmd = aw_addr_reg == `CMD_ADDR;
    wire wr_psel = aw_addr_reg == `PSEL_ADDR;
    wire wr_free = aw_addr_reg == `FREE_ADDR;
    wire wr_ok = wr_txsel || wr_cmd || wr_psel || wr_free || aw_addr_reg == `ARES_ADDR;
    wire wr_do = wr_fire && w_en_reg;
    // bit 4 of a command write never reaches any logic
    cmd_s cmd;
    assign cmd = cmd_s'(w_data_reg);
    wire cmd_go = wr_do && wr_cmd;
    wire cnt_ok = cmd.cnt <= `CNT_MAX;
    wire go_allocation_complete_interrupt = cmd_go && cmd.op == OP_ALLOCATION_COMPLETE_INTERRUPT && cnt_ok && st_reg == ST_IDLE;
    wire go_reset = cmd_go && cmd.op == OP_RESET;
    wire go_pop = cmd_go && (cmd.op == OP_POP || cmd.op == OP_POPREL);
    wire go_enq = cmd_go && cmd.op == OP_ENQ;
    wire go_flush = cmd_go && cmd.op == OP_TXRST;

    // ------------------------------------------------------------
    // page allocation and release
    // ------------------------------------------------------------
    function automatic logic [5:0] lowest_zero(input logic [31:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 31; i >= 0; i--) begin
            if (!v[i]) r = {1'b1, 5'(i)};
        end
        return r;
    endfunction

    function automatic logic [5:0] count_zero(input logic [31:0] v);
        logic [5:0] c;
        c = 6'h00;
        for (int i = 0; i < 32; i++) begin
            c = c + 6'(!v[i]);
        end
        return c;
    endfunction

    logic [31:0] id_busy, rel_hit_a, rel_hit_b;
    wire [5:0] pick = lowest_zero(page_used_reg);
    wire [5:0] free_id = lowest_zero(id_busy);
    wire take_cmd = st_reg == ST_ALLOCATION_COMPLETE_INTERRUPT && pick[5];
    // the nak control keeps the dma engine off the free pages
    wire take_dma = rx_dma_page_req && !nak_reg && pick[5] && !take_cmd;
    wire [4:0] take_tag = take_cmd ? (first_reg ? free_id[4:0] : pkt_reg) : rx_dma_pkt;
    wire [31:0] take_oh = (take_cmd || take_dma) ? (32'h1 << pick[4:0]) : 32'h0;
    // opcode 100 frees the head packet, 101 the selected one
    wire rel_a = cmd_go && (cmd.op == OP_POPREL || cmd.op == OP_REL);
    wire [4:0] rel_pkt = cmd.op == OP_POPREL ? rx_queue_head : packet_select_reg;

    // one owner slot per page; a release clears every page of the packet
    for (genvar i = 0; i < `NUM_PAGES; i++) begin : g_page
        assign rel_hit_a[i] = rel_a && page_used_reg[i] && page_tag_reg[i] == rel_pkt;
        assign rel_hit_b[i] = rx_dma_release && page_used_reg[i] && page_tag_reg[i] == rx_dma_rel_pkt;
        always_comb begin
            id_busy[i] = 1'b0;
            for (int p = 0; p < `NUM_PAGES; p++) begin
                if (page_used_reg[p] && page_tag_reg[p] == 5'(i)) id_busy[i] = 1'b1;
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn || go_reset) begin
                page_used_reg[i] <= 1'b0;
                page_tag_reg[i] <= 5'h00;
            end else if (take_oh[i]) begin
                page_used_reg[i] <= 1'b1;
                page_tag_reg[i] <= take_tag;
            end else if (rel_hit_a[i] || rel_hit_b[i]) begin
                page_used_reg[i] <= 1'b0;
            end
        end
    end

    // allocation engine: one page a cycle, waits while none is free
    always_ff @(posedge aclk) begin
        if (!aresetn || go_reset) begin
            st_reg <= ST_IDLE;
            failed_reg <= 1'b0;
            first_reg <= 1'b0;
            need_reg <= 4'h0;
            pkt_reg <= 5'h00;
            result_pkt_reg <= 5'h00;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (st_reg)
                ST_IDLE: begin
                    if (go_allocation_complete_interrupt) begin
                        st_reg <= ST_ALLOCATION_COMPLETE_INTERRUPT;
                        failed_reg <= 1'b1;
                        first_reg <= 1'b1;
                        need_reg <= cmd.cnt;
                    end
                end
                ST_ALLOCATION_COMPLETE_INTERRUPT: begin
                    if (take_cmd) begin
                        first_reg <= 1'b0;
                        pkt_reg <= take_tag;
                        result_pkt_reg <= take_tag;
                        need_reg <= need_reg - 4'h1;
                        if (need_reg == 4'h0) begin
                            st_reg <= ST_IDLE;
                            failed_reg <= 1'b0;
                            done_reg <= 1'b1;
                        end
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // free count follows the page table one cycle late, so it may lag
    // by a page while an allocation is moving, or by every page of a packet after a release
    always_ff @(posedge aclk) begin
        if (!aresetn) free_cnt_reg <= `FREE_RST;
        else free_cnt_reg <= count_zero(page_used_reg);
    end

    // ------------------------------------------------------------
    // control registers and command pulses
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_queue_select_reg <= 4'h0;
            packet_select_reg <= 5'h00;
            nak_reg <= 1'b0;
        end else if (wr_do) begin
            if (wr_txsel) tx_queue_select_reg <= w_data_reg[3:0];
            if (wr_psel) packet_select_reg <= w_data_reg[4:0];
            if (wr_free) nak_reg <= w_data_reg[`NAK_BIT];
        end
    end

    // queue-side pulses last one cycle; no-op raises none
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_reg <= '0;
            pop_reg <= 1'b0;
            rst_pulse_reg <= 1'b0;
            grant_reg <= 1'b0;
            grant_page_reg <= 5'h00;
        end else begin
            tx_reg.enq <= go_enq;
            tx_reg.flush <= go_flush;
            tx_reg.ep <= tx_queue_select_reg;
            tx_reg.pkt <= packet_select_reg;
            pop_reg <= go_pop;
            rst_pulse_reg <= go_reset;
            grant_reg <= take_dma;
            grant_page_reg <= pick[4:0];
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    // address and data are taken in either order; response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_addr_reg <= 32'h0;
            w_data_reg <= 8'h00;
            w_en_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OK;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= !aw_full_next && !(bvalid_reg && !bready);
            wready_reg <= !w_full_next && !(bvalid_reg && !bready);
            if (aw_hs) aw_addr_reg <= awaddr;
            if (w_hs) begin
                w_data_reg <= wdata[7:0];
                w_en_reg <= wstrb[0];
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? `RESP_OK : `RESP_ERR;
            end else if (bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read data: command reads zero, reserved bits zero
    wire [7:0] rd_ares = {failed_reg, 2'b00, result_pkt_reg};
    wire [7:0] rd_free = {nak_reg, 1'b0, free_cnt_reg};
    wire rd_ok = araddr == `TXSEL_ADDR || araddr == `CMD_ADDR || araddr == `ARES_ADDR
        || araddr == `PSEL_ADDR || araddr == `FREE_ADDR;
    wire [7:0] rd_byte = araddr == `TXSEL_ADDR ? {4'h0, tx_queue_select_reg}
        : araddr == `ARES_ADDR ? rd_ares
        : araddr == `PSEL_ADDR ? {3'h0, packet_select_reg}
        : araddr == `FREE_ADDR ? rd_free : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `RESP_OK;
        end else if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h0, rd_byte};
            rresp_reg <= rd_ok ? `RESP_OK : `RESP_ERR;
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end else if (!rvalid_reg) begin
            arready_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign rx_dma_grant = grant_reg;
    assign rx_dma_page = grant_page_reg;
    assign rx_queue_pop = pop_reg;
    assign receive_nak_control = nak_reg;
    assign tx_cmd = tx_reg;
    assign mmu_reset = rst_pulse_reg;
    assign allocation_complete = done_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_allocation_complete_interrupt_cmd;
        go_allocation_complete_interrupt;
    endsequence
    sequence s_allocation_complete_interrupt_end;
        !failed_reg && allocation_complete;
    endsequence

    property p_fail_set;
        s_allocation_complete_interrupt_cmd |=> failed_reg && st_reg == ST_ALLOCATION_COMPLETE_INTERRUPT;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("failed flag not set");

    property p_done;
        $fell(failed_reg) && !$past(go_reset) |-> s_allocation_complete_interrupt_end;
    endproperty
    a_done: assert property (p_done) else $error("completion pulse missing");

    property p_nop;
        cmd_go && cmd.op == OP_NOP && st_reg == ST_IDLE && !rx_dma_page_req && !rx_dma_release
            |=> $stable(page_used_reg) && $stable(failed_reg) && !tx_cmd.enq && !rx_queue_pop;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");

    property p_bad_cnt;
        cmd_go && cmd.op == OP_ALLOCATION_COMPLETE_INTERRUPT && cmd.cnt > `CNT_MAX && st_reg == ST_IDLE
            |=> st_reg == ST_IDLE && !failed_reg;
    endproperty
    a_bad_cnt: assert property (p_bad_cnt) else $error("oversize allocate taken");

    property p_reset;
        go_reset |=> page_used_reg == 32'h0 && !failed_reg && mmu_reset ##1 free_cnt_reg == `FREE_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("reset command incomplete");

    property p_release;
        rel_a |=> (page_used_reg & $past(rel_hit_a)) == 32'h0;
    endproperty
    a_release: assert property (p_release) else $error("released pages still held");

    property p_enq;
        go_enq |=> tx_cmd.enq && tx_cmd.ep == $past(tx_queue_select_reg)
            && tx_cmd.pkt == $past(packet_select_reg);
    endproperty
    a_enq: assert property (p_enq) else $error("enqueue wrong target");

    property p_flush;
        go_flush |=> tx_cmd.flush && !tx_cmd.enq;
    endproperty
    a_flush: assert property (p_flush) else $error("flush missing");

    property p_pop;
        go_pop |=> rx_queue_pop ##1 !rx_queue_pop;
    endproperty
    a_pop: assert property (p_pop) else $error("pop pulse wrong");

    property p_nak;
        receive_nak_control |-> !take_dma ##1 !rx_dma_grant;
    endproperty
    a_nak: assert property (p_nak) else $error("page granted under nak");

    property p_resume;
        st_reg == ST_ALLOCATION_COMPLETE_INTERRUPT && pick[5] |=> need_reg != $past(need_reg) || st_reg == ST_IDLE;
    endproperty
    a_resume: assert property (p_resume) else $error("pending allocation stalled");
endmodule

// file: bench/rx_dma_model.sv
// behavioural receive dma engine and receive queue head facing the buffer manager
module rx_dma_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench control
    input wire logic want_page,
    input wire logic rel_go,
    input wire logic [4:0] rel_pkt,
    input wire logic [4:0] head_pkt,
    // device side
    output logic rx_dma_page_req,
    output logic [4:0] rx_dma_pkt,
    output logic rx_dma_release,
    output logic [4:0] rx_dma_rel_pkt,
    output logic [4:0] rx_queue_head
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------
    // requests and releases
    // ------------------------------------------------
    // one-cycle page request; nak and priority are left to the device alone
    // reset gives a known start so the inverted idle pattern never stays unknown
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_dma_page_req <= 1'b0;
            rx_dma_pkt <= 5'h00;
            rx_dma_release <= 1'b0;
            rx_dma_rel_pkt <= 5'h00;
        end else begin
            rx_dma_page_req <= want_page;
            rx_dma_pkt <= want_page ? 5'h1E : ~rx_dma_pkt;
            rx_dma_release <= rel_go;
            rx_dma_rel_pkt <= rel_go ? rel_pkt : ~rx_dma_rel_pkt;
        end
    end

    // head of the receive queue is a plain level
    assign rx_queue_head = head_pkt;
endmodule

// file: bench/packet_buffer_mmu_tb_top.sv
// self-checking bench of the buffer manager command and status side
`include "pbm_defs.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH at %0t got %h exp %h", $time, got, exp); end end

module packet_buffer_mmu_tb_top
    import pbm_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk, aresetn;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0] wstrb, ep;
    logic [1:0] bresp, rresp, resp;
    logic rx_dma_page_req, rx_dma_release, rx_dma_grant, rx_queue_pop, receive_nak_control;
    logic mmu_reset, allocation_complete, want_page, rel_go;
    logic [4:0] rx_dma_pkt, rx_dma_rel_pkt, rx_dma_page, rx_queue_head, rel_pkt, head_pkt, pkt;
    logic [4:0] gpage;
    logic [7:0] r;
    logic [7:0] sz [4];
    tx_cmd_s tx_cmd, cmd_last;
    int error_cnt = 0, checked = 0, n_enq = 0, n_flush = 0, n_pop = 0, n_rst = 0, n_done = 0, n_grant = 0;
    int used, seed;

    packet_buffer_mmu packet_buffer_mmu_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .rx_dma_page_req, .rx_dma_pkt, .rx_dma_release, .rx_dma_rel_pkt, .rx_dma_grant,
        .rx_dma_page, .rx_queue_head, .rx_queue_pop, .receive_nak_control, .tx_cmd, .mmu_reset,
        .allocation_complete);
    rx_dma_model rx_dma_model_inst (.aclk, .aresetn, .want_page, .rel_go, .rel_pkt, .head_pkt,
        .rx_dma_page_req, .rx_dma_pkt, .rx_dma_release, .rx_dma_rel_pkt, .rx_queue_head);

    // 40 MHz clock
    initial aclk = 1'b0;
    always #12.5 aclk = ~aclk;

    // pulse counters; values are sampled before this edge's updates land
    always @(posedge aclk) begin
        if (aresetn) begin
            if (tx_cmd.enq === 1'b1 || tx_cmd.flush === 1'b1) cmd_last <= tx_cmd;
            if (tx_cmd.enq === 1'b1) n_enq++;
            if (tx_cmd.flush === 1'b1) n_flush++;
            if (rx_queue_pop === 1'b1) n_pop++;
            if (mmu_reset === 1'b1) n_rst++;
            if (allocation_complete === 1'b1) n_done++;
            if (rx_dma_grant === 1'b1) begin
                n_grant++;
                gpage <= rx_dma_page;
            end
        end
    end

    // ------------------------------------------------
    // bus tasks and expectations
    // ------------------------------------------------
    function automatic logic [7:0] cmd_byte(input logic [2:0] op, input logic [3:0] n);
        return {op, 1'b0, n};
    endfunction

    function automatic logic [7:0] free_byte(input int u);
        return 8'(32 - u);
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // bounded wait: a hang counts as a mismatch and ends the run
    task automatic tick(inout int n);
        n++;
        if (n > 100) begin
            error_cnt++;
            results();
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic ad, wd;
        int n;
        ad = 1'b0;
        wd = 1'b0;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (ad && wd && bvalid === 1'b1) break;
            if (awready === 1'b1) ad = 1'b1;
            if (wready === 1'b1) wd = 1'b1;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
            tick(n);
        end
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
            tick(n);
        end
        d = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask

    // polls the result register until the failed flag drops
    task automatic allocation_complete_interrupt_wait(output logic [7:0] q);
        for (int k = 0; k < 40; k++) begin
            rd(`ARES_ADDR, q);
            if (q[`FAIL_BIT] === 1'b0) return;
        end
        error_cnt++;
        results();
    endtask

    task automatic pulse_want();
        want_page <= 1'b1;
        @(posedge aclk);
        want_page <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {want_page, rel_go, rel_pkt, head_pkt} = '0;
        wstrb = 4'hF;
        aresetn = 1'b0;
        seed = $urandom(94);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`FREE_ADDR, 8'h20);
        rchk(`ARES_ADDR, 8'h00);
        rchk(`CMD_ADDR, 8'h00);
        rchk(32'h00000010, 8'h00);
        `CHK(resp, `RESP_ERR)
        done("reset");
        r = 8'($urandom);
        wr(`PSEL_ADDR, r);
        rchk(`PSEL_ADDR, r & 8'h1F);
        wr(`TXSEL_ADDR, ~r);
        rchk(`TXSEL_ADDR, ~r & 8'h0F);
        wr(`FREE_ADDR, 8'hFF);
        rchk(`FREE_ADDR, 8'hA0);
        `CHK(receive_nak_control, 1'b1)
        wr(`FREE_ADDR, 8'h00);
        wr(`ARES_ADDR, 8'hFF);
        `CHK(resp, `RESP_OK)
        rchk(`ARES_ADDR, 8'h00);
        // opcode 000 with bit 4 and a count set must leave everything alone
        wr(`CMD_ADDR, 8'h1F);
        rchk(`FREE_ADDR, 8'h20);
        `CHK(n_enq + n_flush + n_pop + n_rst + n_done + n_grant, 0)
        done("registers");
        used = 0;
        for (int i = 0; i < 4; i++) begin
            sz[i] = (i == 0) ? 8'h01 : (i == 1) ? 8'h0A : 8'(1 + $urandom % 10);
            wr(`CMD_ADDR, cmd_byte(3'h1, 4'(sz[i] - 8'h01)));
            allocation_complete_interrupt_wait(r);
            used += sz[i];
            `CHK(r, 8'(i))
            `CHK(n_done, i + 1)
            rchk(`FREE_ADDR, free_byte(used));
        end
        wr(`CMD_ADDR, cmd_byte(3'h1, 4'hA));
        rchk(`ARES_ADDR, 8'h03);
        rchk(`FREE_ADDR, free_byte(used));
        for (int i = 0; i < 4; i++) begin
            wr(`PSEL_ADDR, 8'(i));
            wr(`CMD_ADDR, cmd_byte(3'h5, 4'h0));
            used -= sz[i];
            rchk(`FREE_ADDR, free_byte(used));
        end
        done("allocate");
        ep = 4'($urandom);
        pkt = 5'($urandom);
        wr(`TXSEL_ADDR, {4'h0, ep});
        wr(`PSEL_ADDR, {3'h0, pkt});
        wr(`CMD_ADDR, cmd_byte(3'h6, 4'h0));
        repeat (2) @(posedge aclk); // pulses trail the write by one cycle
        `CHK(cmd_last, {1'b1, 1'b0, ep, pkt})
        wr(`CMD_ADDR, cmd_byte(3'h7, 4'h0));
        repeat (2) @(posedge aclk);
        `CHK({cmd_last.flush, cmd_last.ep}, {1'b1, ep})
        `CHK(n_enq + n_flush, 2)
        rchk(`FREE_ADDR, 8'h20);
        done("queues");
        wr(`CMD_ADDR, cmd_byte(3'h1, 4'h1));
        allocation_complete_interrupt_wait(r);
        head_pkt <= r[4:0];
        wr(`CMD_ADDR, cmd_byte(3'h3, 4'h0));
        repeat (2) @(posedge aclk);
        `CHK(n_pop, 1)
        rchk(`FREE_ADDR, 8'h1E);
        wr(`CMD_ADDR, cmd_byte(3'h4, 4'h0));
        repeat (2) @(posedge aclk);
        `CHK(n_pop, 2)
        rchk(`FREE_ADDR, 8'h20);
        done("receive pop");
        for (int i = 0; i < 3; i++) begin
            wr(`CMD_ADDR, cmd_byte(3'h1, 4'h9));
            allocation_complete_interrupt_wait(r);
        end
        // only two pages remain, so this one stalls
        wr(`CMD_ADDR, cmd_byte(3'h1, 4'h9));
        repeat (20) @(posedge aclk);
        rd(`ARES_ADDR, r);
        `CHK(r[`FAIL_BIT], 1'b1)
        rel_pkt <= 5'h00;
        rel_go <= 1'b1;
        @(posedge aclk);
        rel_go <= 1'b0;
        allocation_complete_interrupt_wait(r);
        rchk(`FREE_ADDR, 8'h02);
        done("stalled allocate");
        pulse_want();
        `CHK(n_grant, 1)
        // pages go out lowest first: 8 and 9 were left, so the engine gets 8
        `CHK(gpage, 5'h08)
        rchk(`FREE_ADDR, 8'h01);
        wr(`FREE_ADDR, 8'h80);
        pulse_want();
        `CHK(n_grant, 1)
        rchk(`FREE_ADDR, 8'h81);
        wr(`FREE_ADDR, 8'h00);
        wr(`CMD_ADDR, cmd_byte(3'h1, 4'h9));
        wr(`CMD_ADDR, cmd_byte(3'h2, 4'h0));
        repeat (2) @(posedge aclk);
        `CHK(n_rst, 1)
        rchk(`FREE_ADDR, 8'h20);
        rd(`ARES_ADDR, r);
        `CHK(r[`FAIL_BIT], 1'b0)
        done("dma and reset");
        results();
    end
endmodule
